// ===== logic/lcp_defines.vh
// Behaviour
// R1 - memory clock from bus clock, divide field bits 5-4: 1, 2, 3 or 4
// R2 - software writes zero to reserved bit 0 of memory clock register
// R3 - pixel divide field bits 6-4: 1,2,3,4,8; codes 101-111 reserved
// R4 - pixel source bits 1-0: memory, bus, primary or secondary input clock
// R5 - passive panels, modulation rate zero: modulation toggles every frame pulse
// R6 - modulation rate n non-zero: toggle every n line pulses, counted continuously
// R7 - bit 7 picks 8-bit mono passive data format one or two
// R8 - bit 6 picks monochrome when zero, colour when one
// R9 - width bits 5-4: passive 4/8/16, active 9/12/18, code 11 reserved
// R10 - memory clock register resets to zero, memory clock equals bus clock
// R11 - panel type bits 1-0: passive, active, direct reflective, 11 reserved
// R12 - bit 3 picks direct reflective resolution, ignored for other types
// R13 - writing modulation rate restarts the modulation line counter
`ifndef LCP_DEFINES_VH
`define LCP_DEFINES_VH

// =====================================================
// register map, byte addresses
`define LCP_ADDR_W 4
`define LCP_OFS_MEM_CLK 4'h4
`define LCP_OFS_PIX_CLK 4'h8
`define LCP_OFS_PANEL 4'hC
`define LCP_REG_RESET 32'h00000000

// =====================================================
// field positions
`define LCP_MCLK_DIV_HI 5
`define LCP_MCLK_DIV_LO 4
`define LCP_PDIV_HI 6
`define LCP_PDIV_LO 4
`define LCP_PSRC_HI 1
`define LCP_PSRC_LO 0
`define LCP_MODR_HI 21
`define LCP_MODR_LO 16
`define LCP_FMT_BIT 7
`define LCP_COLOR_BIT 6
`define LCP_WIDTH_HI 5
`define LCP_WIDTH_LO 4
`define LCP_RES_BIT 3
`define LCP_PTYPE_HI 1
`define LCP_PTYPE_LO 0

// =====================================================
// encodings
`define LCP_PSRC_MEM 2'h0
`define LCP_PSRC_BUS 2'h1
`define LCP_PSRC_PRI 2'h2
`define LCP_PSRC_SEC 2'h3
`define LCP_PDIV_1 3'h0
`define LCP_PDIV_2 3'h1
`define LCP_PDIV_3 3'h2
`define LCP_PDIV_4 3'h3
`define LCP_PDIV_8 3'h4
`define LCP_PTYPE_PASSIVE 2'h0
`define LCP_PTYPE_ACTIVE 2'h1
`define LCP_PTYPE_DIRECT 2'h2
`define LCP_WIDTH_W0 2'h0
`define LCP_WIDTH_W1 2'h1
`define LCP_WIDTH_W2 2'h2

`endif

// ===== logic/lcp_clk_div.v
`timescale 1ns/1ps
// =====================================================
// enable divider: one out pulse per (ratio_m1 + 1) in pulses
module lcp_clk_div #(
  parameter W = 3
) (
  input wire sys_clk,
  input wire rst_n,
  input wire restart,
  input wire in_en,
  input wire [W-1:0] ratio_m1,
  output reg out_en
);
  reg [W-1:0] cnt;

  always @(posedge sys_clk) begin
    if (!rst_n || restart) begin
      cnt <= {W{1'b0}};
      out_en <= 1'b0;
    end else begin
      out_en <= 1'b0;
      if (in_en) begin
        if (cnt >= ratio_m1) begin
          cnt <= {W{1'b0}};
          out_en <= 1'b1;
        end else begin
          cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // lcp_clk_div

// ===== logic/lcp_mod_gen.v
`timescale 1ns/1ps
// =====================================================
// ac modulation toggle from frame or line count
module lcp_mod_gen #(
  parameter W = 6
) (
  input wire sys_clk,
  input wire rst_n,
  input wire restart,
  input wire enable,
  input wire frame_evt,
  input wire line_evt,
  input wire [W-1:0] rate,
  output reg mod_out
);
  reg [W-1:0] cnt;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= {W{1'b0}};
      mod_out <= 1'b0;
    end else if (restart) begin
      cnt <= {W{1'b0}}; // R13
    end else if (enable) begin
      if (rate == {W{1'b0}}) begin
        cnt <= {W{1'b0}};
        if (frame_evt) begin
          mod_out <= ~mod_out; // R5
        end
      end else if (line_evt) begin
        if (cnt >= rate - {{(W-1){1'b0}}, 1'b1}) begin
          cnt <= {W{1'b0}};
          mod_out <= ~mod_out; // R6
        end else begin
          cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // lcp_mod_gen

// ===== logic/lcp_top.v
`timescale 1ns/1ps
`include "lcp_defines.vh"
// =====================================================
// lcd clock and panel configuration block
module lcp_top (
  input wire sys_clk,
  input wire rst_n,
  input wire [`LCP_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire primary_input_clock,
  input wire secondary_input_clock,
  input wire frame_pulse,
  input wire line_pulse,
  output reg mem_clk_en,
  output reg pix_clk_en,
  output reg ac_modulation_output,
  output reg pix_div_reserved,
  output reg panel_is_passive,
  output reg panel_is_active,
  output reg panel_is_direct,
  output reg panel_type_reserved,
  output reg direct_res_high,
  output reg panel_color,
  output reg panel_format_two,
  output reg [4:0] panel_data_bits,
  output reg panel_width_reserved
);

  // =====================================================
  // register fields
  reg [1:0] mclk_div;
  reg [2:0] pix_div;
  reg [1:0] pix_src;
  reg [5:0] mod_rate;
  reg fmt_sel;
  reg color_sel;
  reg [1:0] width_sel;
  reg res_sel;
  reg [1:0] panel_type;

  // =====================================================
  // bus handshake
  wire bus_req;
  wire bus_go;
  wire wr_go;
  wire rd_go;
  wire hit_mem;
  wire hit_pix;
  wire hit_panel;
  reg [31:0] next_readdata;

  assign bus_req = avs_read | avs_write;
  assign bus_go = bus_req & avs_waitrequest;
  assign wr_go = avs_write & ~avs_waitrequest;
  assign rd_go = avs_read & avs_waitrequest;
  assign hit_mem = (avs_address == `LCP_OFS_MEM_CLK);
  assign hit_pix = (avs_address == `LCP_OFS_PIX_CLK);
  assign hit_panel = (avs_address == `LCP_OFS_PANEL);

  // one wait cycle, then released for one cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_go) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // =====================================================
  // register writes
  wire wr_mem_b0;
  wire wr_pix_b0;
  wire wr_pan_b0;
  wire wr_pan_b2;

  assign wr_mem_b0 = wr_go & hit_mem & avs_byteenable[0];
  assign wr_pix_b0 = wr_go & hit_pix & avs_byteenable[0];
  assign wr_pan_b0 = wr_go & hit_panel & avs_byteenable[0];
  assign wr_pan_b2 = wr_go & hit_panel & avs_byteenable[2];

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mclk_div <= 2'h0; // R10
      pix_div <= 3'h0;
      pix_src <= 2'h0;
      mod_rate <= 6'h00;
      fmt_sel <= 1'b0;
      color_sel <= 1'b0;
      width_sel <= 2'h0;
      res_sel <= 1'b0;
      panel_type <= 2'h0;
    end else begin
      if (wr_mem_b0) begin
        mclk_div <= avs_writedata[`LCP_MCLK_DIV_HI:`LCP_MCLK_DIV_LO];
      end
      if (wr_pix_b0) begin
        pix_div <= avs_writedata[`LCP_PDIV_HI:`LCP_PDIV_LO];
        pix_src <= avs_writedata[`LCP_PSRC_HI:`LCP_PSRC_LO];
      end
      if (wr_pan_b0) begin
        fmt_sel <= avs_writedata[`LCP_FMT_BIT];
        color_sel <= avs_writedata[`LCP_COLOR_BIT];
        width_sel <= avs_writedata[`LCP_WIDTH_HI:`LCP_WIDTH_LO];
        res_sel <= avs_writedata[`LCP_RES_BIT];
        panel_type <= avs_writedata[`LCP_PTYPE_HI:`LCP_PTYPE_LO];
      end
      if (wr_pan_b2) begin
        mod_rate <= avs_writedata[`LCP_MODR_HI:`LCP_MODR_LO];
      end
    end
  end

  // =====================================================
  // register reads, unmapped reads as zero
  always @* begin
    next_readdata = `LCP_REG_RESET;
    if (hit_mem) begin
      next_readdata[`LCP_MCLK_DIV_HI:`LCP_MCLK_DIV_LO] = mclk_div;
    end else if (hit_pix) begin
      next_readdata[`LCP_PDIV_HI:`LCP_PDIV_LO] = pix_div;
      next_readdata[`LCP_PSRC_HI:`LCP_PSRC_LO] = pix_src;
    end else if (hit_panel) begin
      next_readdata[`LCP_MODR_HI:`LCP_MODR_LO] = mod_rate;
      next_readdata[`LCP_FMT_BIT] = fmt_sel;
      next_readdata[`LCP_COLOR_BIT] = color_sel;
      next_readdata[`LCP_WIDTH_HI:`LCP_WIDTH_LO] = width_sel;
      next_readdata[`LCP_RES_BIT] = res_sel;
      next_readdata[`LCP_PTYPE_HI:`LCP_PTYPE_LO] = panel_type;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= `LCP_REG_RESET;
    end else if (rd_go) begin
      avs_readdata <= next_readdata;
    end
  end

  // =====================================================
  // input sampling and edge detect
  reg pri_prev;
  reg sec_prev;
  reg frame_prev;
  reg line_prev;
  wire pri_edge;
  wire sec_edge;
  wire frame_evt;
  wire line_evt;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pri_prev <= 1'b0;
      sec_prev <= 1'b0;
      frame_prev <= 1'b0;
      line_prev <= 1'b0;
    end else begin
      pri_prev <= primary_input_clock;
      sec_prev <= secondary_input_clock;
      frame_prev <= frame_pulse;
      line_prev <= line_pulse;
    end
  end

  assign pri_edge = primary_input_clock & ~pri_prev;
  assign sec_edge = secondary_input_clock & ~sec_prev;
  assign frame_evt = frame_pulse & ~frame_prev;
  assign line_evt = line_pulse & ~line_prev;

  // =====================================================
  // memory clock divider
  wire mem_div_out;

  lcp_clk_div #(
    .W(2)
  ) u_mem_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(wr_mem_b0),
    .in_en(1'b1),
    .ratio_m1(mclk_div), // R1
    .out_en(mem_div_out)
  );

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_clk_en <= 1'b0;
    end else begin
      mem_clk_en <= mem_div_out;
    end
  end

  // =====================================================
  // pixel clock source select and divider
  reg pix_src_en;
  reg [2:0] pix_ratio_m1;
  reg next_pix_reserved;
  wire pix_div_out;

  always @* begin
    case (pix_src)
      `LCP_PSRC_MEM: pix_src_en = mem_div_out; // R4
      `LCP_PSRC_BUS: pix_src_en = 1'b1; // R4
      `LCP_PSRC_PRI: pix_src_en = pri_edge; // R4
      default: pix_src_en = sec_edge; // R4
    endcase
  end

  always @* begin
    next_pix_reserved = 1'b0;
    case (pix_div)
      `LCP_PDIV_1: pix_ratio_m1 = 3'h0; // R3
      `LCP_PDIV_2: pix_ratio_m1 = 3'h1; // R3
      `LCP_PDIV_3: pix_ratio_m1 = 3'h2; // R3
      `LCP_PDIV_4: pix_ratio_m1 = 3'h3; // R3
      `LCP_PDIV_8: pix_ratio_m1 = 3'h7; // R3
      default: begin
        pix_ratio_m1 = 3'h0;
        next_pix_reserved = 1'b1; // R3
      end
    endcase
  end

  lcp_clk_div #(
    .W(3)
  ) u_pix_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(wr_pix_b0),
    .in_en(pix_src_en),
    .ratio_m1(pix_ratio_m1),
    .out_en(pix_div_out)
  );

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pix_clk_en <= 1'b0;
      pix_div_reserved <= 1'b0;
    end else begin
      pix_clk_en <= pix_div_out;
      pix_div_reserved <= next_pix_reserved;
    end
  end

  // =====================================================
  // ac modulation for passive panels
  wire is_passive;
  wire mod_bit;

  assign is_passive = (panel_type == `LCP_PTYPE_PASSIVE);

  lcp_mod_gen #(
    .W(6)
  ) u_mod (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(wr_pan_b2), // R13
    .enable(is_passive), // R5
    .frame_evt(frame_evt),
    .line_evt(line_evt),
    .rate(mod_rate), // R6
    .mod_out(mod_bit)
  );

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ac_modulation_output <= 1'b0;
    end else begin
      ac_modulation_output <= mod_bit;
    end
  end

  // =====================================================
  // panel configuration decode
  reg [4:0] next_data_bits;
  reg next_width_reserved;

  always @* begin
    next_width_reserved = 1'b0;
    if (panel_type == `LCP_PTYPE_PASSIVE) begin
      case (width_sel)
        `LCP_WIDTH_W0: next_data_bits = 5'h04; // R9
        `LCP_WIDTH_W1: next_data_bits = 5'h08; // R9
        `LCP_WIDTH_W2: next_data_bits = 5'h10; // R9
        default: begin
          next_data_bits = 5'h00;
          next_width_reserved = 1'b1; // R9
        end
      endcase
    end else begin
      case (width_sel)
        `LCP_WIDTH_W0: next_data_bits = 5'h09; // R9
        `LCP_WIDTH_W1: next_data_bits = 5'h0C; // R9
        `LCP_WIDTH_W2: next_data_bits = 5'h12; // R9
        default: begin
          next_data_bits = 5'h00;
          next_width_reserved = 1'b1; // R9
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      panel_is_passive <= 1'b0;
      panel_is_active <= 1'b0;
      panel_is_direct <= 1'b0;
      panel_type_reserved <= 1'b0;
      direct_res_high <= 1'b0;
      panel_color <= 1'b0;
      panel_format_two <= 1'b0;
      panel_data_bits <= 5'h00;
      panel_width_reserved <= 1'b0;
    end else begin
      panel_is_passive <= (panel_type == `LCP_PTYPE_PASSIVE); // R11
      panel_is_active <= (panel_type == `LCP_PTYPE_ACTIVE); // R11
      panel_is_direct <= (panel_type == `LCP_PTYPE_DIRECT); // R11
      panel_type_reserved <= (panel_type == 2'h3); // R11
      direct_res_high <= res_sel & (panel_type == `LCP_PTYPE_DIRECT); // R12
      panel_color <= color_sel; // R8
      panel_format_two <= fmt_sel; // R7
      panel_data_bits <= next_data_bits;
      panel_width_reserved <= next_width_reserved;
    end
  end

endmodule // lcp_top

// ===== testbench/lcp_panel_model.sv
`timescale 1ns/1ps
// ========================================
// panel side pulses and input clock sources
module lcp_panel_model (
  input wire sys_clk,
  output reg frame_pulse = 1'b0,
  output reg line_pulse = 1'b0,
  output reg primary_input_clock = 1'b0,
  output reg secondary_input_clock = 1'b0
);
  reg [1:0] pc = 2'h0;
  reg [2:0] sc = 3'h0;
  // free running sources, periods 4 and 6
  always @(posedge sys_clk) begin
    pc <= pc + 2'h1;
    sc <= (sc == 3'h5) ? 3'h0 : sc + 3'h1;
    primary_input_clock <= pc[1];
    secondary_input_clock <= (sc < 3'h3);
  end
  // one frame or line pulse, then a low gap
  task ev(input f);
    begin
      @(posedge sys_clk);
      if (f) frame_pulse <= 1'b1;
      else line_pulse <= 1'b1;
      @(posedge sys_clk);
      frame_pulse <= 1'b0;
      line_pulse <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
endmodule // lcp_panel_model

// ===== testbench/lcp_top_monitor.sv
`timescale 1ns/1ps
// ========================================
// port checker
module lcp_top_monitor (
  input wire sys_clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire frame_pulse,
  input wire line_pulse,
  input wire mem_clk_en,
  input wire ac_modulation_output,
  input wire panel_is_passive,
  input wire panel_is_active,
  input wire panel_is_direct,
  input wire panel_type_reserved,
  input wire direct_res_high,
  input wire panel_color,
  input wire panel_format_two,
  input wire [4:0] panel_data_bits,
  input wire panel_width_reserved
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not one cycle");
  a_reset_mclk_full: assert property ($rose(rst_n) |-> ##2 mem_clk_en [*2])
    else $error("memory clock not 1:1 after reset");
  a_type_onehot: assert property ($past(rst_n, 2) |->
    $onehot({panel_is_passive, panel_is_active, panel_is_direct, panel_type_reserved}))
    else $error("panel type not one-hot");
  a_res_needs_direct: assert property (direct_res_high |-> panel_is_direct)
    else $error("resolution flag without direct type");
  a_width_passive: assert property (panel_is_passive && !panel_width_reserved |->
    panel_data_bits inside {5'h04, 5'h08, 5'h10})
    else $error("passive width wrong");
  a_width_active: assert property ((panel_is_active || panel_is_direct) && !panel_width_reserved |->
    panel_data_bits inside {5'h09, 5'h0C, 5'h12})
    else $error("active width wrong");
  a_width_resv_zero: assert property (panel_width_reserved |-> panel_data_bits == 5'h00)
    else $error("reserved width not zero");
  a_mod_has_cause: assert property ($changed(ac_modulation_output) |->
    $past(frame_pulse, 2) || $past(line_pulse, 2) || $past(frame_pulse, 3) || $past(line_pulse, 3))
    else $error("modulation toggled without pulse");
  a_cfg_after_write: assert property ($changed({panel_color, panel_format_two}) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("panel config changed without write");
  cover property ($rose(ac_modulation_output));
  cover property (panel_is_direct && direct_res_high);
  cover property (panel_width_reserved);
endmodule // lcp_top_monitor

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
// ========================================
// self-checking bench
module tb_top;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg [3:0] avs_byteenable = 4'hF;
  reg [31:0] avs_writedata = 32'h0;
  reg [31:0] rdat;
  integer num_errors = 0;
  integer checks_done = 0;
  integer m, p, k;
  wire [31:0] avs_readdata;
  wire [4:0] panel_data_bits;
  wire avs_waitrequest, primary_input_clock, secondary_input_clock, frame_pulse, line_pulse, mem_clk_en;
  wire pix_clk_en, ac_modulation_output, pix_div_reserved, panel_is_passive, panel_is_active, panel_is_direct;
  wire panel_type_reserved, direct_res_high, panel_color, panel_format_two, panel_width_reserved;
  lcp_top u_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .primary_input_clock, .secondary_input_clock, .frame_pulse, .line_pulse,
    .mem_clk_en, .pix_clk_en, .ac_modulation_output, .pix_div_reserved, .panel_is_passive, .panel_is_active,
    .panel_is_direct, .panel_type_reserved, .direct_res_high, .panel_color, .panel_format_two, .panel_data_bits,
    .panel_width_reserved);
  lcp_panel_model u_pnl (.sys_clk, .frame_pulse, .line_pulse, .primary_input_clock, .secondary_input_clock);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task test_done;
    begin
      if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] x, input [31:0] g, input [8*11:1] what);
    begin
      checks_done = checks_done + 1;
      if (g !== x) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s expected %0h seen %0h", what, x, g);
      end
    end
  endtask
  // one avalon access, held until waitrequest low
  task bus(input wr, input [3:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      i = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && i < 20) begin
        @(posedge sys_clk);
        i = i + 1;
      end
      rdat = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i == 20) begin
        num_errors = num_errors + 1;
        $display("[ERR] waitrequest expected 0 seen 1");
        test_done;
      end
    end
  endtask
  task rb(input [3:0] a, input [31:0] x);
    begin
      bus(1'b0, a, 32'h0);
      chk(x, rdat, "readback");
    end
  endtask
  task cnt(input integer n);
    begin
      m = 0;
      p = 0;
      repeat (n) begin
        @(posedge sys_clk);
        m = m + mem_clk_en;
        p = p + pix_clk_en;
      end
    end
  endtask
  task pc(input [6:0] v, input [31:0] x);
    begin
      bus(1'b1, 4'h8, {25'h0, v});
      repeat (16) @(posedge sys_clk);
      cnt(48);
      chk(x, p, "pix rate");
      chk({31'h0, v[6:4] > 3'h4}, {31'h0, pix_div_reserved}, "pix resv");
    end
  endtask
  task t_regs;
    begin
      cnt(12);
      chk(12, m, "mclk reset");
      chk(12, p, "pclk reset");
      rb(4'h4, 32'h0);
      rb(4'h8, 32'h0);
      rb(4'hC, 32'h0);
      bus(1'b1, 4'h0, 32'hFFFFFFFF);
      rb(4'h0, 32'h0);
      rb(4'h8, 32'h0);
      avs_byteenable <= 4'hE;
      bus(1'b1, 4'h8, 32'h13);
      rb(4'h8, 32'h0);
      avs_byteenable <= 4'hF;
    end
  endtask
  task t_clk;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        bus(1'b1, 4'h4, k << 4);
        repeat (8) @(posedge sys_clk);
        cnt(24);
        chk(24 / (k + 1), m, "mclk rate");
      end
      pc(7'h00, 12);
      bus(1'b1, 4'h4, 32'h10);
      pc(7'h00, 24);
      bus(1'b1, 4'h4, 32'h0);
      pc(7'h01, 48);
      pc(7'h11, 24);
      pc(7'h21, 16);
      pc(7'h31, 12);
      pc(7'h41, 6);
      pc(7'h51, 48);
      pc(7'h02, 12);
      pc(7'h12, 6);
      pc(7'h13, 4);
      rb(4'h8, 32'h13);
    end
  endtask
  task t_panel;
    reg [31:0] v;
    reg [4:0] b;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        v = {24'h0, k[3], k[0] ^ k[2], k[3:2], k[2], 1'b0, k[1:0]};
        bus(1'b1, 4'hC, v);
        rb(4'hC, v);
        repeat (3) @(posedge sys_clk);
        chk({k[1:0] == 2'h0, k[1:0] == 2'h1, k[1:0] == 2'h2, k[1:0] == 2'h3, v[3] && k[1:0] == 2'h2, v[6], v[7],
          k[3:2] == 2'h3}, {panel_is_passive, panel_is_active, panel_is_direct, panel_type_reserved,
          direct_res_high, panel_color, panel_format_two, panel_width_reserved}, "panel flags");
        b = (k[3:2] == 2'h3) ? 5'h00 : (k[1:0] == 2'h0) ? (5'h04 << k[3:2]) : 5'h09 + 5'h03 * k[3:2] + 5'h03 * k[3];
        if (k[1:0] != 2'h3) chk(b, panel_data_bits, "data bits");
      end
    end
  endtask
  task lp(input f, input x);
    begin
      u_pnl.ev(f);
      repeat (3) @(posedge sys_clk);
      chk(x, ac_modulation_output, "mod level");
    end
  endtask
  task t_mod;
    begin
      bus(1'b1, 4'hC, 32'h0);
      lp(1'b1, 1'b1);
      lp(1'b1, 1'b0);
      lp(1'b0, 1'b0);
      bus(1'b1, 4'hC, 32'h00030000);
      lp(1'b0, 1'b0);
      lp(1'b0, 1'b0);
      lp(1'b1, 1'b0);
      lp(1'b0, 1'b1);
      lp(1'b0, 1'b1);
      lp(1'b0, 1'b1);
      bus(1'b1, 4'hC, 32'h00030000);
      lp(1'b0, 1'b1);
      lp(1'b0, 1'b1);
      lp(1'b0, 1'b0);
      bus(1'b1, 4'hC, 32'h00010001);
      lp(1'b0, 1'b0);
      lp(1'b1, 1'b0);
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs;
    t_clk;
    t_panel;
    t_mod;
    test_done;
  end
endmodule // tb_top
bind lcp_top lcp_top_monitor u_mon (.sys_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .frame_pulse,
  .line_pulse, .mem_clk_en, .ac_modulation_output, .panel_is_passive, .panel_is_active, .panel_is_direct,
  .panel_type_reserved, .direct_res_high, .panel_color, .panel_format_two, .panel_data_bits, .panel_width_reserved);
